// *** adm_decoder.sv ***
// Addressing mode decoder: operand fetch and effective address forming
// How it works
// (RULE1) Seventeen modes grouped into seven classes
// (RULE2) Long form reaches whole 64 Kbyte space
// (RULE3) Short form addresses page zero, except indexed short forms, which add the index and reach up to 01FE
// (RULE4) Read-modify-write ops refuse long form
// (RULE5) Branch offset applies to next-instruction PC
// (RULE6) Inherent: one byte, no operand fetch
// (RULE7) Immediate: one operand byte used directly
// (RULE8) Direct: instruction address is operand location
// (RULE9) Short direct: one address byte
// (RULE10) Long direct: two address bytes
// (RULE11) Indexed: unsigned index plus offset
// (RULE12) Relative: signed 8-bit displacement added
// (RULE13) Indirect: page-zero pointer, byte or word
// (RULE14) Words assembled high byte first
`timescale 1ns/10ps
`default_nettype none
module adm_decoder (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [4:0] mode,
    input wire logic rmw_op,
    input wire logic use_y,
    input wire logic [15:0] opcode_pc,
    input wire logic [7:0] idx_x,
    input wire logic [7:0] idx_y,
    input wire logic mem_rdy,
    input wire logic [7:0] mem_rdata,
    output logic [15:0] mem_addr_r,
    output logic mem_rd_r,
    output logic busy_r,
    output logic done_r,
    output logic mode_err_r,
    output logic [15:0] ea_r,
    output logic [7:0] operand_r,
    output logic [15:0] target_r,
    output logic [15:0] next_pc_r,
    output logic [2:0] len_r,
    output logic [2:0] class_r
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_PTR,
        ST_CALC
    } adm_state_type;

    adm_state_type state_r;
    adm_pkg::adm_mode_type mode_r;
    adm_pkg::adm_mode_type mode_in;
    logic [15:0] pc_r;
    logic [7:0] idx_r;
    logic [7:0] opnd_r [0:1];
    logic [15:0] ptr_r;
    logic [1:0] cnt_r;
    logic [1:0] opnd_n;
    logic [1:0] ptr_n;
    logic take;
    logic last;
    logic [7:0] ptr_addr;
    adm_ea_if ea_bus ();

    assign mode_in = adm_pkg::adm_mode_type'(mode);
    assign opnd_n = adm_pkg::opnd_bytes(mode_r);
    assign ptr_n = adm_pkg::ptr_bytes(mode_r);
    assign take = mem_rd_r && mem_rdy;
    // Pointer address is operand byte 0: on the bus now or already stored
    assign ptr_addr = (cnt_r == 2'h0) ? mem_rdata : opnd_r[0];

    always_comb begin
        unique case (state_r)
            ST_FETCH: last = (cnt_r == opnd_n - 2'h1);
            ST_PTR: last = (cnt_r == ptr_n - 2'h1);
            default: last = 1'b0;
        endcase
    end

    assign ea_bus.mode = mode_r;
    assign ea_bus.opnd0 = opnd_r[0];
    assign ea_bus.opnd1 = opnd_r[1];
    assign ea_bus.ptr = ptr_r;
    assign ea_bus.idx = idx_r;
    assign ea_bus.next_pc = pc_r + adm_pkg::OPCODE_BYTES + {14'h0000, opnd_n};

    adm_ea_calc u_calc (
        .ea(ea_bus.calc)
    );

    // Sequencer
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            cnt_r <= 2'h0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    cnt_r <= 2'h0;
                    if (start && !(rmw_op && adm_pkg::long_form(mode_in))) begin // (RULE4)
                        if (adm_pkg::opnd_bytes(mode_in) == 2'h0) begin
                            state_r <= ST_CALC; // (RULE6)
                        end else begin
                            state_r <= ST_FETCH;
                        end
                    end
                end
                ST_FETCH: begin
                    if (take) begin
                        cnt_r <= last ? 2'h0 : cnt_r + 2'h1;
                        if (last) begin
                            state_r <= (ptr_n != 2'h0) ? ST_PTR : ST_CALC;
                        end
                    end
                end
                ST_PTR: begin
                    if (take) begin
                        cnt_r <= cnt_r + 2'h1;
                        if (last) begin
                            state_r <= ST_CALC;
                        end
                    end
                end
                ST_CALC: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Instruction context captured at start
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_r <= adm_pkg::ADM_INH;
            pc_r <= 16'h0000;
            idx_r <= 8'h00;
        end else if (state_r == ST_IDLE && start) begin
            mode_r <= mode_in;
            pc_r <= opcode_pc;
            idx_r <= use_y ? idx_y : idx_x; // (RULE11)
        end
    end

    // Operand and pointer bytes, high byte first
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            opnd_r[0] <= 8'h00;
            opnd_r[1] <= 8'h00;
            ptr_r <= 16'h0000;
        end else if (state_r == ST_IDLE && start) begin
            opnd_r[0] <= 8'h00;
            opnd_r[1] <= 8'h00;
            ptr_r <= 16'h0000;
        end else if (take && state_r == ST_FETCH) begin
            opnd_r[cnt_r[0]] <= mem_rdata; // (RULE14)
        end else if (take && state_r == ST_PTR) begin
            ptr_r <= {ptr_r[7:0], mem_rdata}; // (RULE13) (RULE14)
        end
    end

    // Memory read requests held until the bus answers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_rd_r <= 1'b0;
            mem_addr_r <= 16'h0000;
        end else if (state_r == ST_IDLE) begin
            mem_rd_r <= start && !(rmw_op && adm_pkg::long_form(mode_in)) &&
                        (adm_pkg::opnd_bytes(mode_in) != 2'h0);
            mem_addr_r <= opcode_pc + adm_pkg::OPCODE_BYTES;
        end else if (take && state_r == ST_FETCH && !last) begin
            mem_addr_r <= mem_addr_r + 16'h0001;
        end else if (take && state_r == ST_FETCH) begin
            mem_rd_r <= (ptr_n != 2'h0);
            mem_addr_r <= {adm_pkg::PAGE_ZERO_HI, ptr_addr}; // (RULE13)
        end else if (take && state_r == ST_PTR) begin
            mem_rd_r <= !last;
            // Word pointer low byte may sit just above page zero
            mem_addr_r <= mem_addr_r + 16'h0001;
        end
    end

    // Results
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            done_r <= 1'b0;
            mode_err_r <= 1'b0;
            ea_r <= 16'h0000;
            operand_r <= 8'h00;
            target_r <= 16'h0000;
            next_pc_r <= 16'h0000;
            len_r <= 3'h0;
            class_r <= 3'h0;
        end else begin
            done_r <= (state_r == ST_CALC);
            mode_err_r <= (state_r == ST_IDLE) && start && rmw_op &&
                          adm_pkg::long_form(mode_in); // (RULE4)
            if (state_r == ST_CALC) begin
                ea_r <= ea_bus.ea;
                operand_r <= ea_bus.imm; // (RULE7)
                target_r <= ea_bus.target; // (RULE5)
                next_pc_r <= ea_bus.next_pc;
                len_r <= {1'b0, opnd_n} + 3'h1; // (RULE6) (RULE7)
                class_r <= 3'(adm_pkg::mode_class(mode_r)); // (RULE1)
            end
        end
    end

    // Busy mirrors the sequencer being away from idle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_r <= 1'b0;
        end else if (state_r == ST_IDLE) begin
            busy_r <= start && !(rmw_op && adm_pkg::long_form(mode_in)); // (RULE4)
        end else begin
            busy_r <= (state_r != ST_CALC);
        end
    end
endmodule // adm_decoder
`default_nettype wire

// *** adm_pkg.sv ***
// Constants, mode enumeration and mode decoding functions for the decoder
package adm_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int MODE_W = 5;
    localparam int MODE_COUNT = 17;
    localparam int CLASS_COUNT = 7;
    localparam logic [7:0] PAGE_ZERO_HI = 8'h00;
    localparam logic [15:0] OPCODE_BYTES = 16'h0001;
    localparam logic [1:0] MAX_OPND_BYTES = 2'h2;

    // Seventeen modes in seven classes
    typedef enum logic [4:0] {
        ADM_INH,
        ADM_IMM,
        ADM_DIR_S,
        ADM_DIR_L,
        ADM_IDX_0,
        ADM_IDX_S,
        ADM_IDX_L,
        ADM_IND_S,
        ADM_IND_L,
        ADM_INDX_S,
        ADM_INDX_L,
        ADM_REL_D,
        ADM_REL_I,
        ADM_BIT_D,
        ADM_BIT_I,
        ADM_BITREL_D,
        ADM_BITREL_I
    } adm_mode_type;

    typedef enum logic [2:0] {
        ADM_CLS_INHERENT,
        ADM_CLS_IMMEDIATE,
        ADM_CLS_DIRECT,
        ADM_CLS_INDEXED,
        ADM_CLS_INDIRECT,
        ADM_CLS_RELATIVE,
        ADM_CLS_BIT
    } adm_class_type;

    // Operand bytes that follow the opcode in the instruction stream
    function automatic logic [1:0] opnd_bytes(input adm_mode_type m);
        unique case (m)
            ADM_INH, ADM_IDX_0: opnd_bytes = 2'h0;
            ADM_DIR_L, ADM_IDX_L,
            ADM_BITREL_D, ADM_BITREL_I: opnd_bytes = 2'h2;
            default: opnd_bytes = 2'h1;
        endcase
    endfunction

    // Bytes read through the page-zero pointer
    function automatic logic [1:0] ptr_bytes(input adm_mode_type m);
        unique case (m)
            ADM_IND_L, ADM_INDX_L: ptr_bytes = 2'h2;
            ADM_IND_S, ADM_INDX_S, ADM_REL_I,
            ADM_BIT_I, ADM_BITREL_I: ptr_bytes = 2'h1;
            default: ptr_bytes = 2'h0;
        endcase
    endfunction

    function automatic logic long_form(input adm_mode_type m);
        long_form = (m == ADM_DIR_L) || (m == ADM_IDX_L) ||
                    (m == ADM_IND_L) || (m == ADM_INDX_L);
    endfunction

    function automatic adm_class_type mode_class(input adm_mode_type m);
        unique case (m)
            ADM_INH: mode_class = ADM_CLS_INHERENT;
            ADM_IMM: mode_class = ADM_CLS_IMMEDIATE;
            ADM_DIR_S, ADM_DIR_L: mode_class = ADM_CLS_DIRECT;
            ADM_IDX_0, ADM_IDX_S, ADM_IDX_L: mode_class = ADM_CLS_INDEXED;
            ADM_IND_S, ADM_IND_L,
            ADM_INDX_S, ADM_INDX_L: mode_class = ADM_CLS_INDIRECT;
            ADM_REL_D, ADM_REL_I: mode_class = ADM_CLS_RELATIVE;
            default: mode_class = ADM_CLS_BIT;
        endcase
    endfunction

endpackage

// *** adm_ea_if.sv ***
// Interface carrying fetched bytes to the effective address unit
`timescale 1ns/10ps
`default_nettype none
interface adm_ea_if;
    adm_pkg::adm_mode_type mode;
    logic [7:0] opnd0;
    logic [7:0] opnd1;
    logic [15:0] ptr;
    logic [7:0] idx;
    logic [15:0] next_pc;
    logic [15:0] ea;
    logic [15:0] target;
    logic [7:0] imm;

    modport calc (
        input mode, opnd0, opnd1, ptr, idx, next_pc,
        output ea, target, imm
    );
    modport user (
        output mode, opnd0, opnd1, ptr, idx, next_pc,
        input ea, target, imm
    );
endinterface
`default_nettype wire

// *** adm_ea_calc.sv ***
// Effective address and branch target arithmetic
`timescale 1ns/10ps
`default_nettype none
module adm_ea_calc (
    adm_ea_if.calc ea
);
    logic [15:0] word_opnd;
    logic [15:0] idx_w;
    logic [7:0] disp;

    // High byte comes from the lower address
    assign word_opnd = {ea.opnd0, ea.opnd1}; // (RULE14)
    assign idx_w = {8'h00, ea.idx};
    assign ea.imm = ea.opnd0; // (RULE7)

    always_comb begin
        unique case (ea.mode)
            adm_pkg::ADM_REL_I: disp = ea.ptr[7:0];
            // Bit-test branches carry the displacement after the operand byte
            adm_pkg::ADM_BITREL_D, adm_pkg::ADM_BITREL_I: disp = ea.opnd1;
            default: disp = ea.opnd0;
        endcase
    end

    // Displacement counts from the already advanced program counter
    assign ea.target = ea.next_pc + {{8{disp[7]}}, disp}; // (RULE5) (RULE12)

    always_comb begin
        unique case (ea.mode)
            adm_pkg::ADM_DIR_S, adm_pkg::ADM_BIT_D, adm_pkg::ADM_BITREL_D:
                ea.ea = {adm_pkg::PAGE_ZERO_HI, ea.opnd0}; // (RULE8) (RULE9) (RULE3)
            adm_pkg::ADM_DIR_L:
                ea.ea = word_opnd; // (RULE10) (RULE2)
            adm_pkg::ADM_IDX_0:
                ea.ea = idx_w;
            adm_pkg::ADM_IDX_S:
                ea.ea = {8'h00, ea.opnd0} + idx_w; // (RULE11)
            adm_pkg::ADM_IDX_L:
                ea.ea = word_opnd + idx_w; // (RULE11)
            adm_pkg::ADM_IND_S, adm_pkg::ADM_BIT_I, adm_pkg::ADM_BITREL_I:
                ea.ea = {adm_pkg::PAGE_ZERO_HI, ea.ptr[7:0]}; // (RULE13)
            adm_pkg::ADM_IND_L:
                ea.ea = ea.ptr; // (RULE13)
            adm_pkg::ADM_INDX_S:
                ea.ea = {8'h00, ea.ptr[7:0]} + idx_w;
            adm_pkg::ADM_INDX_L:
                ea.ea = ea.ptr + idx_w;
            default:
                ea.ea = 16'h0000;
        endcase
    end
endmodule // adm_ea_calc
`default_nettype wire

// *** adm_decoder_monitor.sv ***
// Concurrent checks on the decoder's top-level ports
`timescale 1ns/10ps
`default_nettype none
module adm_decoder_monitor (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [4:0] mode,
    input wire logic rmw_op,
    input wire logic [15:0] opcode_pc,
    input wire logic mem_rdy,
    input wire logic [15:0] mem_addr_r,
    input wire logic mem_rd_r,
    input wire logic busy_r,
    input wire logic done_r,
    input wire logic mode_err_r,
    input wire logic [15:0] ea_r,
    input wire logic [15:0] next_pc_r,
    input wire logic [2:0] len_r,
    input wire logic [2:0] class_r
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic [15:0] pc_r;
    wire take = start && !busy_r;
    wire lng = mode == 5'h03 || mode == 5'h06 || mode == 5'h08 ||
               mode == 5'h0a;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) pc_r <= 16'h0000;
        else if (take) pc_r <= opcode_pc;
    end
    // A refusal must not leak into a read or a late completion
    sequence refused_s;
        mode_err_r && !mem_rd_r ##1 !done_r && !mem_rd_r;
    endsequence
    refuse_long_a: assert property (
        take && rmw_op && lng |=> refused_s)
        else $error("long form accepted for rmw");
    err_pulse_a: assert property (mode_err_r |=> !mode_err_r)
        else $error("error pulse too long");
    inh_timing_a: assert property (
        take && mode == 5'h00 |-> ##2 done_r && len_r == 3'h1)
        else $error("inherent timing or length wrong");
    imm_fetch_a: assert property (
        take && mode == 5'h01 |=>
            mem_rd_r && mem_addr_r == $past(opcode_pc) + 16'h0001)
        else $error("immediate byte not fetched after opcode");
    read_hold_a: assert property (
        mem_rd_r && !mem_rdy |=> mem_rd_r && $stable(mem_addr_r))
        else $error("read request dropped early");
    done_pulse_a: assert property (done_r |=> !done_r)
        else $error("done longer than one cycle");
    next_pc_a: assert property (
        done_r |-> next_pc_r == pc_r + {13'h0000, len_r})
        else $error("next pc not opcode plus length");
    page_zero_a: assert property (
        done_r && (class_r == 3'h6 || class_r == 3'h2 && len_r == 3'h2)
            |-> ea_r[15:8] == 8'h00)
        else $error("short form left page zero");
    class_range_a: assert property (
        done_r |-> class_r <= 3'h6 && !mem_rd_r)
        else $error("bad class or read open at done");
    start_answer_a: assert property (
        take && !(rmw_op && lng) |-> ##[2:60] done_r)
        else $error("no completion");
    busy_read_a: assert property (mem_rd_r |-> busy_r)
        else $error("read request while idle");
    idle_at_done_a: assert property (done_r |-> !busy_r)
        else $error("still busy at completion");
endmodule // adm_decoder_monitor
bind adm_decoder adm_decoder_monitor adm_decoder_monitor_i (
    .core_clk(core_clk), .rst_b(rst_b), .start(start), .mode(mode),
    .rmw_op(rmw_op), .opcode_pc(opcode_pc), .mem_rdy(mem_rdy),
    .mem_addr_r(mem_addr_r), .mem_rd_r(mem_rd_r), .busy_r(busy_r),
    .done_r(done_r), .mode_err_r(mode_err_r), .ea_r(ea_r),
    .next_pc_r(next_pc_r), .len_r(len_r), .class_r(class_r));
`default_nettype wire

// *** adm_mem_model.sv ***
// Behavioural program and data memory answering the decoder's reads
`timescale 1ns/10ps
`default_nettype none
package adm_mem_pkg;
    function automatic logic [7:0] mem_byte(input logic [15:0] a);
        mem_byte = a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h3c;
    endfunction
endpackage
module adm_mem_model (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic slow,
    input wire logic mem_rd_r,
    input wire logic [15:0] mem_addr_r,
    output logic mem_rdy,
    output logic [7:0] mem_rdata,
    output logic [7:0] reads
);
    integer seed = 7;
    logic [7:0] junk;
    // Junk alternating 00 and 34 while not ready, so early sampling can match by luck only where the byte is 00 or 34
    assign mem_rdata = mem_rdy ? adm_mem_pkg::mem_byte(mem_addr_r) : junk;
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_rdy <= 1'b0;
            junk <= 8'h00;
            reads <= 8'h00;
        end else begin
            junk <= ~junk + 8'h35;
            mem_rdy <= !slow || $random(seed) & 1;
            if (mem_rd_r && mem_rdy) reads <= reads + 8'h01;
        end
    end
endmodule // adm_mem_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the addressing mode decoder
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic core_clk, rst_b, start, rmw_op, use_y, slow;
    logic mem_rdy, mem_rd_r, busy_r, done_r, mode_err_r;
    logic [4:0] mode;
    logic [15:0] opcode_pc, mem_addr_r, ea_r, target_r, next_pc_r;
    logic [7:0] idx_x, idx_y, mem_rdata, operand_r, reads;
    logic [2:0] len_r, class_r;
    logic [31:0] r, s;
    integer seed = 99, num_errors = 0, checks = 0;
    localparam logic [2:0] LEN [17] = '{1,2,2,3,1,2,3,2,2,2,2,2,2,2,2,3,3};
    localparam logic [2:0] CLS [17] = '{0,1,2,2,3,3,3,4,4,4,4,5,5,6,6,6,6};
    localparam logic [7:0] PTR [17] = '{0,0,0,0,0,0,0,1,2,1,2,0,1,0,1,0,1};
    adm_decoder adm_decoder_i (.core_clk(core_clk), .rst_b(rst_b),
        .start(start), .mode(mode), .rmw_op(rmw_op), .use_y(use_y),
        .opcode_pc(opcode_pc), .idx_x(idx_x), .idx_y(idx_y),
        .mem_rdy(mem_rdy), .mem_rdata(mem_rdata), .mem_addr_r(mem_addr_r),
        .mem_rd_r(mem_rd_r), .busy_r(busy_r), .done_r(done_r),
        .mode_err_r(mode_err_r), .ea_r(ea_r), .operand_r(operand_r),
        .target_r(target_r), .next_pc_r(next_pc_r), .len_r(len_r),
        .class_r(class_r));
    adm_mem_model adm_mem_model_i (.core_clk(core_clk), .rst_b(rst_b),
        .slow(slow), .mem_rd_r(mem_rd_r), .mem_addr_r(mem_addr_r),
        .mem_rdy(mem_rdy), .mem_rdata(mem_rdata), .reads(reads));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task report_and_stop;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task cmp_addr(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task cmp_small(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] mb(input logic [15:0] a);
        mb = adm_mem_pkg::mem_byte(a);
    endfunction
    task run(input int m, input logic rmw, input logic [15:0] pc,
             input logic [7:0] ix, input logic [7:0] iy, input logic uy,
             input logic sl);
        logic [7:0] b1, b2, i, d, r0;
        logic [15:0] p, w, ea, np;
        logic rf;
        int n;
        b1 = mb(pc + 16'h0001);
        b2 = mb(pc + 16'h0002);
        p = {8'h00, b1};
        w = {mb(p), mb(p + 16'h0001)};
        i = uy ? iy : ix;
        np = pc + {13'h0000, LEN[m]};
        d = m == 11 ? b1 : m inside {15, 16} ? b2 : mb(p);
        rf = rmw && m inside {3, 6, 8, 10};
        case (m)
            3: ea = {b1, b2};
            4: ea = {8'h00, i};
            5: ea = p + {8'h00, i};
            6: ea = {b1, b2} + {8'h00, i};
            7, 14, 16: ea = {8'h00, mb(p)};
            8: ea = w;
            9: ea = {8'h00, mb(p)} + {8'h00, i};
            10: ea = w + {8'h00, i};
            default: ea = p;
        endcase
        @(posedge core_clk);
        r0 = reads;
        mode <= m[4:0];
        rmw_op <= rmw;
        opcode_pc <= pc;
        idx_x <= ix;
        idx_y <= iy;
        use_y <= uy;
        slow <= sl;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        #1;
        cmp_small({7'h00, busy_r}, {7'h00, !rf});
        n = 0;
        while (n < 100 && done_r !== 1'b1 && mode_err_r !== 1'b1) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        cmp_small({6'h00, mode_err_r, done_r}, {6'h00, rf, !rf});
        if (rf) begin
            repeat (3) @(posedge core_clk);
            cmp_small(reads - r0, 8'h00);
        end else begin
            cmp_small({5'h00, len_r}, {5'h00, LEN[m]});
            cmp_small({5'h00, class_r}, {5'h00, CLS[m]});
            cmp_addr(next_pc_r, np);
            cmp_small(reads - r0, {5'h00, LEN[m]} - 8'h01 + PTR[m]);
            if (m == 1) cmp_small(operand_r, b1);
            if (m inside {[2:10], [13:16]}) cmp_addr(ea_r, ea);
            if (m inside {11, 12, 15, 16}) cmp_addr(target_r, np + {{8{d[7]}}, d});
        end
    endtask
    initial begin
        repeat (40000) @(posedge core_clk);
        num_errors++;
        report_and_stop;
    end
    initial begin
        rst_b = 1'b0;
        start = 1'b0;
        mode = 5'h00;
        rmw_op = 1'b0;
        use_y = 1'b0;
        slow = 1'b0;
        opcode_pc = 16'h0000;
        idx_x = 8'h00;
        idx_y = 8'h00;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        // Indexed reach limit and both displacement extremes
        run(5, 0, 16'h00c2, 8'hff, 8'h00, 0, 0);
        run(11, 0, 16'h00bb, 8'h00, 8'h00, 0, 1);
        run(11, 0, 16'h0042, 8'h00, 8'h00, 0, 0);
        for (int k = 0; k < 17; k++) run(k, 1, 16'hfff0, 8'h12, 8'h34, 1, 0);
        repeat (300) begin
            r = $random(seed);
            s = $random(seed);
            run(int'(s[7:0]) % 17, s[8], r[15:0], r[23:16], r[31:24], s[9], s[10]);
        end
        report_and_stop;
    end
endmodule // testbench
`default_nettype wire
